/* File: rtl/ppp_port.sv */
// device side of the high-voltage parallel programming port
// Notes on behaviour
// - ready_busy_out low while programming or erasing
// - device drives data only while read_drive_n low
// - byte_sel_lo_hi picks low or high byte
// - byte_sel_ext picks the extended fuse byte
// - page_latch_strobe moves data into page buffer
// - entry pattern 0000 latched at high voltage
// - load clock pulse acts on action code
// - write or read pulse runs latest command
// - decode the nine documented command bytes
// - flash pages of 64 or 128 words
// - eeprom pages of 4 or 8 bytes
// - power down or reset leaves programming mode
// - command and address retained across operations
// - erase clears flash, locks, and eeprom unless the keep fuse is programmed; fuses kept
// - erase: load command, write pulse, busy low
// - flash page collected then programmed at once
// - page strobe with high select latches word
// - no-operation command resets write signals
`timescale 1ns/1ps
module ppp_port
  import ppp_pkg::*;
#(
  parameter int FLASH_AW     = 15,  // word address width
  parameter int FLASH_PAGE_W = 7,   // word_in_page_index width (6 or 7)
  parameter int EE_AW        = 10,  // eeprom byte address width
  parameter int EE_PAGE_W    = 3,   // eeprom in-page width (2 or 3)
  parameter logic [7:0] SIG0 = 8'h5A,  // arbitrary identity value
  parameter logic [7:0] SIG1 = 8'h3C,  // arbitrary identity value
  parameter logic [7:0] SIG2 = 8'h21,  // arbitrary identity value
  parameter logic [7:0] CAL  = 8'h80   // arbitrary calibration value
) (
  input  wire logic       i_mclk,
  input  wire logic       i_resetn,
  input  wire logic       i_hv_applied,
  input  wire logic       i_load_strobe_clock,
  input  wire logic       i_page_latch_strobe,
  input  wire logic       i_xtal_action_bit1,
  input  wire logic       i_xtal_action_bit0,
  input  wire logic       i_byte_sel_lo_hi,
  input  wire logic       i_byte_sel_ext,
  input  wire logic       i_write_strobe_n,
  input  wire logic       i_read_drive_n,
  input  wire logic [7:0] i_data,
  output logic      [7:0] o_data,
  output logic      [7:0] o_data_oe_n,
  output logic            o_ready_busy_out,
  output logic            o_prog_mode
);

  // two-stage synchronisers for every pin
  // every programmer pin is asynchronous to i_mclk; the whole group passes the
  // same two stages so the strobes and the data they qualify stay aligned
  // a third register gives the previous value for edge detection
  // cost: every pin event is seen two clocks late, far below the pulse width
  localparam int NP = $bits(ppp_pins_s);
  logic [NP-1:0] pin_raw;
  logic [NP-1:0] sync1_q, sync2_q, prev_q;
  logic          hv1_q, hv2_q, hv_prev_q;
  ppp_pins_s     p, pp;

  assign pin_raw = {i_page_latch_strobe, i_xtal_action_bit1, i_xtal_action_bit0, i_byte_sel_lo_hi,
                    i_byte_sel_ext, i_write_strobe_n, i_read_drive_n, i_load_strobe_clock, i_data};

  // first stage is read only by the second
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      sync1_q   <= '0;
      sync2_q   <= '0;
      prev_q    <= '0;
      hv1_q     <= 1'b0;
      hv2_q     <= 1'b0;
      hv_prev_q <= 1'b0;
    end else begin
      sync1_q   <= pin_raw;
      sync2_q   <= sync1_q;
      prev_q    <= sync2_q;
      hv1_q     <= i_hv_applied;
      hv2_q     <= hv1_q;
      hv_prev_q <= hv2_q;
    end
  end

  assign p  = ppp_pins_s'(sync2_q);
  assign pp = ppp_pins_s'(prev_q);

  // edge events on the synchronised strobes
  // the sync registers reset to zero, so the active-low strobes show a rising
  // edge after reset, never a falling one; no false write follows reset
  wire load_rise = p.load_strobe_clock & ~pp.load_strobe_clock;
  wire page_rise = p.page_latch_strobe & ~pp.page_latch_strobe;
  wire wr_fall   = ~p.write_strobe_n & pp.write_strobe_n;
  wire hv_rise   = hv2_q & ~hv_prev_q;

  // entry pattern check at the high-voltage edge
  // the pattern is read from the same sync stage as the voltage edge, so a
  // pattern that changes during the voltage edge is judged consistently
  wire entry_ok = ({p.page_latch_strobe, p.xtal_action_bit1, p.xtal_action_bit0, p.byte_sel_lo_hi}
                   == PPP_ENTRY_PATTERN);

  // command decode helpers
  function automatic logic is_write_cmd(input logic [7:0] c);
    is_write_cmd = (c == PPP_CMD_ERASE) || (c == PPP_CMD_WR_FUSE) || (c == PPP_CMD_WR_LOCK) ||
                   (c == PPP_CMD_WR_FLASH) || (c == PPP_CMD_WR_EE);
  endfunction : is_write_cmd

  // state of the port
  typedef enum {PPP_ST_OFF, PPP_ST_IDLE, PPP_ST_BUSY, PPP_ST_ERASE} ppp_state_e;
  ppp_state_e   st_q, st_d;
  logic         mode_q;                 // programming mode latched
  logic [7:0]   cmd_q;                  // last loaded command
  logic [15:0]  addr_q;                 // loaded address
  logic [7:0]   dlo_q, dhi_q;           // loaded data bytes
  logic [7:0]   fuse_lo_q, fuse_hi_q, fuse_ext_q, lock_q;
  logic [15:0]  page_buf_q [0:(1<<FLASH_PAGE_W)-1];  // flash page buffer
  logic [7:0]   ee_buf_q   [0:(1<<EE_PAGE_W)-1];     // eeprom page buffer
  logic [15:0]  ptr_q;                  // word/byte index during program or erase
  logic [31:0]  tmr_q;                  // operation time counter
  logic         erase_ee_q;             // erase includes eeprom
  ppp_op_e      op_q;

  // programming mode: caught after high voltage, dropped by reset
  // mode is also dropped when the high voltage goes away, which stands for
  // the reset pin being pulled back towards ground
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      mode_q <= 1'b0;
    end else if (hv_rise && entry_ok) begin
      mode_q <= 1'b1;
    end else if (!hv2_q) begin
      mode_q <= 1'b0;
    end
  end

  wire idle     = (st_q == PPP_ST_IDLE);
  wire act_load = mode_q && idle && load_rise;

  // command, address and data loads; values held until reloaded
  // loads are refused while an operation runs, so a stray load strobe during
  // busy can never change the page being programmed
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      cmd_q  <= PPP_CMD_NOP;
      addr_q <= PPP_ADDR_RST;
      dlo_q  <= PPP_ERASED_BYTE;
      dhi_q  <= PPP_ERASED_BYTE;
    end else if (act_load) begin
      case ({p.xtal_action_bit1, p.xtal_action_bit0})
        PPP_ACT_ADDR: begin
          if (p.byte_sel_lo_hi) addr_q[15:8] <= p.data;
          else addr_q[7:0] <= p.data;
        end
        PPP_ACT_DATA: begin
          if (p.byte_sel_lo_hi) dhi_q <= p.data;
          else dlo_q <= p.data;
        end
        PPP_ACT_CMD: cmd_q <= p.data;  // loading nop clears write intent
        default: ;  // idle code does nothing
      endcase
    end
  end

  // address fields
  wire [FLASH_PAGE_W-1:0] word_in_page_index = addr_q[FLASH_PAGE_W-1:0];
  wire [EE_PAGE_W-1:0]    ee_in_page         = addr_q[EE_PAGE_W-1:0];
  wire                    is_flash_cmd       = (cmd_q == PPP_CMD_WR_FLASH);
  wire                    is_ee_cmd          = (cmd_q == PPP_CMD_WR_EE);

  // page buffer fill on the page strobe with high byte select
  // the buffers refill with the erased value at reset and after each page
  // program, so words the programmer skipped are written as erased, not stale
  wire buf_clr = (st_q == PPP_ST_BUSY) && (st_d == PPP_ST_IDLE);
  always_ff @(posedge i_mclk) begin
    if (!i_resetn || buf_clr) begin
      for (int i = 0; i < (1 << FLASH_PAGE_W); i++) begin
        page_buf_q[i] <= {PPP_ERASED_BYTE, PPP_ERASED_BYTE};
      end
      for (int j = 0; j < (1 << EE_PAGE_W); j++) begin
        ee_buf_q[j] <= PPP_ERASED_BYTE;
      end
    end else if (mode_q && idle && page_rise && p.byte_sel_lo_hi) begin
      if (is_flash_cmd) page_buf_q[word_in_page_index] <= {dhi_q, dlo_q};
      if (is_ee_cmd) ee_buf_q[ee_in_page] <= dlo_q;
    end
  end

  // write pulse starts the operation of the last command
  wire wr_go = mode_q && idle && wr_fall && is_write_cmd(cmd_q);

  // fuse and lock storage; fuses survive erase
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      fuse_lo_q  <= PPP_FUSE_RST;
      fuse_hi_q  <= PPP_FUSE_RST;
      fuse_ext_q <= PPP_FUSE_RST;
      lock_q     <= PPP_LOCK_RST;
    end else if (wr_go && cmd_q == PPP_CMD_WR_FUSE) begin
      if (p.byte_sel_ext) fuse_ext_q <= dlo_q;
      else if (p.byte_sel_lo_hi) fuse_hi_q <= dlo_q;
      else fuse_lo_q <= dlo_q;
    end else if (wr_go && cmd_q == PPP_CMD_WR_LOCK) begin
      lock_q <= lock_q & dlo_q;  // bits only program to zero
    end else if (st_q == PPP_ST_ERASE && tmr_q == 32'd0 && ptr_q == 16'((1 << FLASH_AW) - 1)) begin
      lock_q <= PPP_LOCK_RST;  // locks clear on the edge that erases the last flash word
    end
  end

  // sequencer: busy phases for page program and chip erase
  // a fixed wait models the programming time, then one location is written
  // per clock; fuse and lock writes pass through the same busy phase with no
  // memory write, so the programmer sees one uniform busy handshake
  wire flash_last = (ptr_q == 16'((1 << FLASH_AW) - 1));
  wire page_last  = is_flash_cmd ? (ptr_q[FLASH_PAGE_W-1:0] == '1) : (ptr_q[EE_PAGE_W-1:0] == '1);

  always_comb begin
    st_d = st_q;
    case (st_q)
      PPP_ST_OFF:   if (mode_q) st_d = PPP_ST_IDLE;
      PPP_ST_IDLE: begin
        if (!mode_q) st_d = PPP_ST_OFF;
        else if (wr_go && cmd_q == PPP_CMD_ERASE) st_d = PPP_ST_ERASE;
        else if (wr_go) st_d = PPP_ST_BUSY;
      end
      PPP_ST_BUSY:  if (tmr_q == 32'd0 && page_last) st_d = PPP_ST_IDLE;
      PPP_ST_ERASE: if (tmr_q == 32'd0 && flash_last) st_d = PPP_ST_IDLE;
      default:      st_d = PPP_ST_OFF;
    endcase
  end

  // pointer and timer follow the state
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      st_q       <= PPP_ST_OFF;
      ptr_q      <= 16'h0000;
      tmr_q      <= 32'd0;
      erase_ee_q <= 1'b0;
      op_q       <= PPP_OP_NONE;
    end else begin
      st_q <= st_d;
      if (st_q == PPP_ST_IDLE && st_d == PPP_ST_ERASE) begin
        ptr_q      <= 16'h0000;
        tmr_q      <= 32'(PPP_ERASE_CYCLES);
        erase_ee_q <= fuse_hi_q[PPP_KEEP_EE_BIT];  // programmed (0) keeps eeprom
        op_q       <= PPP_OP_ERASE;
      end else if (st_q == PPP_ST_IDLE && st_d == PPP_ST_BUSY) begin
        ptr_q <= is_flash_cmd ? {addr_q[15:FLASH_PAGE_W], FLASH_PAGE_W'(0)}
                              : {addr_q[15:EE_PAGE_W], EE_PAGE_W'(0)};
        tmr_q <= 32'(PPP_PROG_CYCLES);
        op_q  <= is_flash_cmd ? PPP_OP_FLASH : (is_ee_cmd ? PPP_OP_EE : PPP_OP_NONE);
      end else if (st_q == PPP_ST_BUSY || st_q == PPP_ST_ERASE) begin
        if (tmr_q != 32'd0) tmr_q <= tmr_q - 32'd1;
        else ptr_q <= ptr_q + 16'h0001;  // walk one location per step after the wait
      end else begin
        op_q <= PPP_OP_NONE;
      end
    end
  end

  // memory write port: one location per cycle once the timer has run out
  wire                step    = (tmr_q == 32'd0);
  wire                fl_we   = step && ((st_q == PPP_ST_BUSY && op_q == PPP_OP_FLASH) ||
                                         st_q == PPP_ST_ERASE);
  wire                ee_we   = step && ((st_q == PPP_ST_BUSY && op_q == PPP_OP_EE) ||
                                         (st_q == PPP_ST_ERASE && erase_ee_q &&
                                          ptr_q < 16'(1 << EE_AW)));
  wire [15:0]         fl_wd   = (st_q == PPP_ST_ERASE) ? {PPP_ERASED_BYTE, PPP_ERASED_BYTE}
                                                      : page_buf_q[ptr_q[FLASH_PAGE_W-1:0]];
  wire [7:0]          ee_wd   = (st_q == PPP_ST_ERASE) ? PPP_ERASED_BYTE : ee_buf_q[ptr_q[EE_PAGE_W-1:0]];
  wire [15:0]         fl_rd;
  wire [7:0]          ee_rd;

  ppp_mem #(.AW(FLASH_AW), .DW(16)) u_flash (
    .i_mclk  (i_mclk),
    .i_we    (fl_we),
    .i_waddr (ptr_q[FLASH_AW-1:0]),
    .i_wdata (fl_wd),
    .i_raddr (addr_q[FLASH_AW-1:0]),
    .o_rdata (fl_rd)
  );

  // eeprom array; erase skips it when the keep fuse is programmed
  ppp_mem #(.AW(EE_AW), .DW(8)) u_eeprom (
    .i_mclk  (i_mclk),
    .i_we    (ee_we),
    .i_waddr (ptr_q[EE_AW-1:0]),
    .i_wdata (ee_wd),
    .i_raddr (addr_q[EE_AW-1:0]),
    .o_rdata (ee_rd)
  );

  // read mux, selected by command and byte selects
  // memory read data is registered, so a new address shows two clocks after
  // it is loaded; the programmer's read strobe is far longer than that
  // signature reads use only the two low address bits; higher ones alias
  logic [7:0] rd_mux;
  always_comb begin
    case (cmd_q)
      PPP_CMD_RD_FLASH: rd_mux = p.byte_sel_lo_hi ? fl_rd[15:8] : fl_rd[7:0];
      PPP_CMD_RD_EE:    rd_mux = ee_rd;
      PPP_CMD_RD_SIG:   rd_mux = p.byte_sel_lo_hi ? CAL :
                                 (addr_q[1:0] == 2'h0) ? SIG0 : (addr_q[1:0] == 2'h1) ? SIG1 : SIG2;
      PPP_CMD_RD_FUSE:  case ({p.byte_sel_ext, p.byte_sel_lo_hi})
                          2'b00:   rd_mux = fuse_lo_q;
                          2'b11:   rd_mux = fuse_hi_q;
                          2'b10:   rd_mux = fuse_ext_q;
                          default: rd_mux = lock_q;
                        endcase
      default:          rd_mux = 8'h00;
    endcase
  end

  // output pins, all registered
  // ready follows the next state so busy shows in the clock after the write
  // edge is seen; the drive enable is all-or-nothing over the data bus
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      o_data           <= 8'h00;
      o_data_oe_n      <= 8'hFF;
      o_ready_busy_out <= 1'b1;
      o_prog_mode      <= 1'b0;
    end else begin
      o_data           <= rd_mux;
      o_data_oe_n      <= {8{~(mode_q && !p.read_drive_n)}};
      o_ready_busy_out <= (st_d == PPP_ST_IDLE) || (st_d == PPP_ST_OFF);
      o_prog_mode      <= mode_q;
    end
  end
endmodule : ppp_port

/* File: rtl/ppp_pkg.sv */
// package for the parallel programming port: constants, codes and carriers
package ppp_pkg;

  // action codes on the two action bits
  localparam logic [1:0] PPP_ACT_ADDR = 2'h0;
  localparam logic [1:0] PPP_ACT_DATA = 2'h1;
  localparam logic [1:0] PPP_ACT_CMD  = 2'h2;
  localparam logic [1:0] PPP_ACT_IDLE = 2'h3;

  // command byte codes
  localparam logic [7:0] PPP_CMD_NOP      = 8'h00;
  localparam logic [7:0] PPP_CMD_ERASE    = 8'h80;
  localparam logic [7:0] PPP_CMD_WR_FUSE  = 8'h40;
  localparam logic [7:0] PPP_CMD_WR_LOCK  = 8'h20;
  localparam logic [7:0] PPP_CMD_WR_FLASH = 8'h10;
  localparam logic [7:0] PPP_CMD_WR_EE    = 8'h11;
  localparam logic [7:0] PPP_CMD_RD_SIG   = 8'h08;
  localparam logic [7:0] PPP_CMD_RD_FUSE  = 8'h04;
  localparam logic [7:0] PPP_CMD_RD_FLASH = 8'h02;
  localparam logic [7:0] PPP_CMD_RD_EE    = 8'h03;

  // entry pattern on page strobe, action bits and byte select
  localparam logic [3:0] PPP_ENTRY_PATTERN = 4'h0;

  // reset values
  localparam logic [7:0]  PPP_ERASED_BYTE = 8'hFF;
  localparam logic [15:0] PPP_ADDR_RST    = 16'h0000;
  localparam logic [7:0]  PPP_FUSE_RST    = 8'hFF;
  localparam logic [7:0]  PPP_LOCK_RST    = 8'hFF;

  // position of the keep-eeprom bit in the high fuse byte
  localparam int PPP_KEEP_EE_BIT = 3;

  // timing: clock period and internal operation times
  localparam int PPP_CLK_PS        = 4000;
  localparam int PPP_PROG_TIME_NS  = 4000;
  localparam int PPP_PROG_CYCLES   = (PPP_PROG_TIME_NS * 1000) / PPP_CLK_PS;
  localparam int PPP_ERASE_TIME_NS = 8000;
  localparam int PPP_ERASE_CYCLES  = (PPP_ERASE_TIME_NS * 1000) / PPP_CLK_PS;

  // synchronised pin group from the programmer
  typedef struct packed {
    logic       page_latch_strobe;
    logic       xtal_action_bit1;
    logic       xtal_action_bit0;
    logic       byte_sel_lo_hi;
    logic       byte_sel_ext;
    logic       write_strobe_n;
    logic       read_drive_n;
    logic       load_strobe_clock;
    logic [7:0] data;
  } ppp_pins_s;

  // internal operation kinds
  typedef enum logic [1:0] {PPP_OP_FLASH, PPP_OP_EE, PPP_OP_ERASE, PPP_OP_NONE} ppp_op_e;

endpackage : ppp_pkg

/* File: rtl/ppp_mem.sv */
// small memory with separate write and read addresses and registered read data
`timescale 1ns/1ps
module ppp_mem #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  input  wire logic          i_mclk,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [DW-1:0] i_wdata,
  input  wire logic [AW-1:0] i_raddr,
  output logic      [DW-1:0] o_rdata
);
  // storage array; contents are unknown until erased
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // write and registered read in one process
  always_ff @(posedge i_mclk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule : ppp_mem

/* File: bench/ppp_port_assertions.sv */
// concurrent checks on the programming port pins
`timescale 1ns/1ps
module ppp_port_assertions (
  input wire logic       i_mclk,
  input wire logic       i_resetn,
  input wire logic       i_hv_applied,
  input wire logic       i_load_strobe_clock,
  input wire logic       i_page_latch_strobe,
  input wire logic       i_xtal_action_bit1,
  input wire logic       i_xtal_action_bit0,
  input wire logic       i_byte_sel_lo_hi,
  input wire logic       i_byte_sel_ext,
  input wire logic       i_write_strobe_n,
  input wire logic       i_read_drive_n,
  input wire logic [7:0] i_data,
  input wire logic [7:0] o_data,
  input wire logic [7:0] o_data_oe_n,
  input wire logic       o_ready_busy_out,
  input wire logic       o_prog_mode
);
  logic [3:0] wr_age_q; // cycles since the write strobe was last low, saturating
  // age counter lets busy be tied to a recent write pulse
  always_ff @(posedge i_mclk) begin
    if (!i_resetn || !i_write_strobe_n) wr_age_q <= 4'h0;
    else if (wr_age_q != 4'hF) wr_age_q <= wr_age_q + 4'h1;
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  chk_reset_state: assert property (disable iff (1'b0) !i_resetn |=> o_ready_busy_out && !o_prog_mode)
    else $error("port not idle after reset");
  chk_oe_needs_read: assert property (i_read_drive_n [*8] |-> o_data_oe_n == 8'hFF)
    else $error("data driven without read strobe");
  chk_oe_whole_bus: assert property (o_data_oe_n == 8'hFF || o_data_oe_n == 8'h00)
    else $error("data bus enable split");
  chk_oe_needs_mode: assert property ((!o_prog_mode) [*3] |-> o_data_oe_n == 8'hFF)
    else $error("data driven outside programming mode");
  chk_busy_from_write: assert property ($fell(o_ready_busy_out) |-> wr_age_q < 4'h8)
    else $error("busy without write pulse");
  chk_busy_min_len: assert property ($fell(o_ready_busy_out) |-> !o_ready_busy_out [*8])
    else $error("busy pulse too short");
  chk_ready_outside: assert property ((!o_prog_mode) [*3] |-> o_ready_busy_out)
    else $error("busy outside programming mode");
  chk_mode_entry: assert property ($rose(o_prog_mode) |-> i_hv_applied && !i_page_latch_strobe
    && !i_xtal_action_bit1 && !i_xtal_action_bit0 && !i_byte_sel_lo_hi)
    else $error("mode entered without entry pattern");
  chk_mode_exit: assert property ($fell(i_hv_applied) |-> ##[1:6] !o_prog_mode)
    else $error("mode kept after high voltage removed");
  cov_busy: cover property ($fell(o_ready_busy_out));
  cov_entry: cover property ($rose(o_prog_mode));
  cov_read: cover property (o_data_oe_n == 8'h00);
endmodule : ppp_port_assertions

/* File: bench/ppp_programmer.sv */
// behavioural parallel programmer driving the port pins
`timescale 1ns/1ps
module ppp_programmer (
  input  wire logic       i_mclk,
  input  wire logic [7:0] i_bus,
  input  wire logic       i_ready,
  output ppp_pkg::ppp_pins_s o_pins,
  output logic            o_hv
);
  import ppp_pkg::*;
  localparam int PULSE = 63; // strobe width of 252 ns at 4 ns a cycle
  // entry pattern pins all zero, strobes idle
  initial begin
    o_pins = '0;
    o_pins.write_strobe_n = 1'b1;
    o_pins.read_drive_n = 1'b1;
    o_hv = 1'b0;
  end
  // every pin change lands just after a clock edge
  task automatic w(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask : w
  // high voltage on, pattern held 10 us, then 290 us before commands
  task automatic enter();
    o_hv = 1'b1;
    w(2500);
    w(72500);
  endtask : enter
  task automatic leave();
    o_hv = 1'b0;
  endtask : leave
  // one load strobe with action code, byte select and data held around it
  task automatic load(input logic [1:0] act, input logic bs1, input logic [7:0] d);
    {o_pins.xtal_action_bit1, o_pins.xtal_action_bit0} = act;
    o_pins.byte_sel_lo_hi = bs1;
    o_pins.data = d;
    w(PULSE);
    o_pins.load_strobe_clock = 1'b1;
    w(PULSE);
    o_pins.load_strobe_clock = 1'b0;
    w(PULSE);
  endtask : load
  // page strobe with high byte select
  task automatic latch();
    o_pins.byte_sel_lo_hi = 1'b1;
    w(PULSE);
    o_pins.page_latch_strobe = 1'b1;
    w(PULSE);
    o_pins.page_latch_strobe = 1'b0;
    w(PULSE);
  endtask : latch
  // write pulse, then wait for ready before anything else
  task automatic wr(input logic bs1, input logic bs2, output logic busy, output logic done);
    o_pins.byte_sel_lo_hi = bs1;
    o_pins.byte_sel_ext = bs2;
    w(PULSE);
    o_pins.write_strobe_n = 1'b0;
    w(PULSE);
    o_pins.write_strobe_n = 1'b1;
    busy = !i_ready;
    done = 1'b0;
    for (int i = 0; i < 40000 && !done; i++) begin
      done = i_ready;
      w(1);
    end
    o_pins.byte_sel_ext = 1'b0;
  endtask : wr
  // read strobe; our drive released, line shows the inverse of the last value
  task automatic rd(input logic bs1, input logic bs2, output logic [7:0] d);
    o_pins.byte_sel_lo_hi = bs1;
    o_pins.byte_sel_ext = bs2;
    o_pins.data = ~o_pins.data;
    o_pins.read_drive_n = 1'b0;
    w(PULSE);
    d = i_bus;
    o_pins.read_drive_n = 1'b1;
    w(PULSE);
  endtask : rd
endmodule : ppp_programmer

/* File: bench/ppp_port_tb.sv */
// self-checking bench for the programming port
`timescale 1ns/1ps
module ppp_port_tb;
  import ppp_pkg::*;
  localparam logic [7:0] SIG[3] = '{8'h6B, 8'h42, 8'h17}; // arbitrary identity values
  localparam logic [7:0] CALV = 8'h80;                     // arbitrary calibration value
  logic       i_mclk = 1'b0;
  logic       i_resetn = 1'b0;
  logic       hv;
  logic [7:0] bus, o_data, oe_n, v;
  logic       rdy, pmode;
  ppp_pins_s  pins;
  int         errors = 0;
  int         comparisons = 0;
  assign bus = (~oe_n & o_data) | (oe_n & pins.data); // resolved data bus
  ppp_port #(.FLASH_AW(8), .FLASH_PAGE_W(6), .EE_AW(5), .EE_PAGE_W(2), .SIG0(SIG[0]), .SIG1(SIG[1]),
    .SIG2(SIG[2])) u_dut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_hv_applied(hv),
    .i_load_strobe_clock(pins.load_strobe_clock), .i_page_latch_strobe(pins.page_latch_strobe),
    .i_xtal_action_bit1(pins.xtal_action_bit1), .i_xtal_action_bit0(pins.xtal_action_bit0),
    .i_byte_sel_lo_hi(pins.byte_sel_lo_hi), .i_byte_sel_ext(pins.byte_sel_ext),
    .i_write_strobe_n(pins.write_strobe_n), .i_read_drive_n(pins.read_drive_n), .i_data(bus),
    .o_data(o_data), .o_data_oe_n(oe_n), .o_ready_busy_out(rdy), .o_prog_mode(pmode));
  ppp_programmer u_prog (.i_mclk(i_mclk), .i_bus(bus), .i_ready(rdy), .o_pins(pins), .o_hv(hv));
  always #2 i_mclk = ~i_mclk;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic cmd(input logic [7:0] c);
    u_prog.load(PPP_ACT_CMD, 1'b0, c);
  endtask : cmd
  task automatic wrchk(input logic bs1, input logic bs2);
    logic b, d;
    u_prog.wr(bs1, bs2, b, d);
    chk({7'h0, b}, 8'h01);
    chk({7'h0, d}, 8'h01);
  endtask : wrchk
  task automatic rdchk(input logic bs1, input logic bs2, input logic [7:0] exp);
    u_prog.rd(bs1, bs2, v);
    chk(v, exp);
  endtask : rdchk
  task automatic t_erase();
    cmd(PPP_CMD_ERASE);
    wrchk(1'b0, 1'b0);
  endtask : t_erase
  task automatic t_flash();
    cmd(PPP_CMD_WR_FLASH); // only two words loaded, erased ones skipped
    u_prog.load(PPP_ACT_ADDR, 1'b0, 8'h05);
    u_prog.load(PPP_ACT_DATA, 1'b0, 8'h34);
    u_prog.load(PPP_ACT_DATA, 1'b1, 8'h12);
    u_prog.latch();
    u_prog.load(PPP_ACT_ADDR, 1'b0, 8'h06);
    u_prog.load(PPP_ACT_DATA, 1'b0, 8'hCD);
    u_prog.load(PPP_ACT_DATA, 1'b1, 8'hAB);
    u_prog.latch();
    u_prog.load(PPP_ACT_ADDR, 1'b1, 8'h00);
    wrchk(1'b0, 1'b0);
    cmd(PPP_CMD_NOP);
    cmd(PPP_CMD_RD_FLASH);
    u_prog.load(PPP_ACT_ADDR, 1'b0, 8'h05);
    rdchk(1'b0, 1'b0, 8'h34);
    rdchk(1'b1, 1'b0, 8'h12);
    u_prog.load(PPP_ACT_ADDR, 1'b0, 8'h06);
    u_prog.load(PPP_ACT_IDLE, 1'b0, 8'h07);
    rdchk(1'b0, 1'b0, 8'hCD);
    rdchk(1'b1, 1'b0, 8'hAB);
    u_prog.load(PPP_ACT_ADDR, 1'b0, 8'h07);
    rdchk(1'b0, 1'b0, 8'hFF);
  endtask : t_flash
  task automatic t_fuse_lock();
    cmd(PPP_CMD_WR_FUSE);
    u_prog.load(PPP_ACT_DATA, 1'b0, 8'hA5);
    wrchk(1'b0, 1'b0);
    u_prog.load(PPP_ACT_DATA, 1'b0, 8'hF7);
    wrchk(1'b1, 1'b0);
    u_prog.load(PPP_ACT_DATA, 1'b0, 8'h0C);
    wrchk(1'b0, 1'b1);
    cmd(PPP_CMD_WR_LOCK);
    u_prog.load(PPP_ACT_DATA, 1'b0, 8'hFC);
    wrchk(1'b0, 1'b0);
    cmd(PPP_CMD_RD_FUSE);
    rdchk(1'b0, 1'b0, 8'hA5);
    rdchk(1'b1, 1'b1, 8'hF7);
    rdchk(1'b0, 1'b1, 8'h0C);
    rdchk(1'b1, 1'b0, 8'hFC);
  endtask : t_fuse_lock
  task automatic t_ee_keep();
    cmd(PPP_CMD_WR_EE);
    u_prog.load(PPP_ACT_ADDR, 1'b0, 8'h02);
    u_prog.load(PPP_ACT_DATA, 1'b0, 8'h5A);
    u_prog.latch();
    wrchk(1'b0, 1'b0);
    cmd(PPP_CMD_RD_EE);
    rdchk(1'b0, 1'b0, 8'h5A);
    t_erase();
    cmd(PPP_CMD_RD_EE);
    rdchk(1'b0, 1'b0, 8'h5A);
    cmd(PPP_CMD_RD_FLASH);
    u_prog.load(PPP_ACT_ADDR, 1'b0, 8'h05);
    rdchk(1'b0, 1'b0, 8'hFF);
    cmd(PPP_CMD_RD_FUSE);
    rdchk(1'b0, 1'b0, 8'hA5);
    rdchk(1'b1, 1'b0, 8'hFF);
  endtask : t_ee_keep
  task automatic t_sig();
    cmd(PPP_CMD_RD_SIG);
    for (int i = 0; i < 3; i++) begin
      u_prog.load(PPP_ACT_ADDR, 1'b0, 8'(i));
      rdchk(1'b0, 1'b0, SIG[i]);
    end
    u_prog.load(PPP_ACT_ADDR, 1'b0, 8'h00);
    rdchk(1'b1, 1'b0, CALV);
  endtask : t_sig
  // watchdog covers entry wait plus all operations with margin
  initial begin
    #440_000;
    errors++;
    tally_and_finish();
  end
  initial begin
    repeat (2) @(posedge i_mclk);
    #1 i_resetn = 1'b1;
    u_prog.w(2);
    chk(oe_n, 8'hFF);
    chk({7'h0, rdy}, 8'h01);
    chk({7'h0, pmode}, 8'h00);
    u_prog.enter();
    chk({7'h0, pmode}, 8'h01);
    t_erase();
    t_flash();
    t_fuse_lock();
    t_ee_keep();
    t_sig();
    u_prog.leave();
    u_prog.w(10);
    chk({7'h0, pmode}, 8'h00);
    chk(oe_n, 8'hFF);
    tally_and_finish();
  end
endmodule : ppp_port_tb
bind ppp_port ppp_port_assertions u_chk (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_hv_applied(i_hv_applied),
  .i_load_strobe_clock(i_load_strobe_clock), .i_page_latch_strobe(i_page_latch_strobe),
  .i_xtal_action_bit1(i_xtal_action_bit1), .i_xtal_action_bit0(i_xtal_action_bit0),
  .i_byte_sel_lo_hi(i_byte_sel_lo_hi), .i_byte_sel_ext(i_byte_sel_ext), .i_write_strobe_n(i_write_strobe_n),
  .i_read_drive_n(i_read_drive_n), .i_data(i_data), .o_data(o_data), .o_data_oe_n(o_data_oe_n),
  .o_ready_busy_out(o_ready_busy_out), .o_prog_mode(o_prog_mode));
